// ==== hw/purge_pkg.sv ====
/*
  Constants, register offsets and types for the purge control and output
  mode block. Assumes a 200 MHz core clock and 16-bit register words.
*/
package purge_pkg;

  // ==========================================================================
  // Register word addresses
  // ==========================================================================
  localparam logic [15:0] ADDR_TRIG     = 16'h0502;
  localparam logic [15:0] ADDR_CH1_MODE = 16'h0700;
  localparam logic [15:0] ADDR_CH1_ERR  = 16'h0706;
  localparam logic [15:0] ADDR_CH2_MODE = 16'h0800;
  localparam logic [15:0] ADDR_CH2_ERR  = 16'h0806;

  // ==========================================================================
  // Register values and reset values
  // ==========================================================================
  localparam logic [15:0] TRIG_START    = 16'h0001;
  localparam logic [15:0] TRIG_OK       = 16'h0000;
  localparam logic [15:0] TRIG_FAIL     = 16'hffff;  // Signed -1.
  localparam logic [15:0] TRIG_RST      = 16'h0000;
  localparam logic [6:0]  PCT_FIRST     = 7'h01;
  localparam logic [6:0]  PCT_MAX       = 7'h64;     // 100 percent.
  localparam logic [15:0] MODE_OFF      = 16'h0000;
  localparam logic [15:0] MODE_RST      = 16'h0001;  // Output on.
  localparam logic [15:0] ERR_LEVEL_RST = 16'h0e10;  // 3600 uA.
  localparam logic [15:0] LEVEL_ZERO    = 16'h0000;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int          CLK_HZ        = 200_000_000;
  localparam int          MS_PER_S      = 1000;
  localparam int          MS_CYCLES     = CLK_HZ / MS_PER_S;
  localparam int          PURGE_TIME_MS = 240_000;   // 4 minutes.
  localparam int          STEP_MS       = PURGE_TIME_MS / 100;
  localparam int          BOOT_LIMIT_MS = 300_000;   // 5 minutes.
  localparam logic [2:0]  SETTLE_LAST   = 3'h4;      // Strap synchroniser fill.

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {BOOT_SETTLE, BOOT_PURGE, BOOT_RUN} boot_e;

endpackage

// ==== hw/purge_if.sv ====
/*
  Interface between the purge controller and the purge sequencer.
  Assumes both ends run on the core clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface purge_if;
  logic       tick;   // One-cycle pulse per millisecond.
  logic       start;  // One-cycle start request.
  logic       spoil;  // Marks the running purge as failed.
  logic       busy;
  logic       done;   // One-cycle pulse at the end of a purge.
  logic       ok;
  logic [6:0] pct;

  modport ctrl (output tick, start, spoil, input busy, done, ok, pct);
  modport seq  (input tick, start, spoil, output busy, done, ok, pct);
endinterface
`default_nettype wire

// ==== hw/purge_seq.sv ====
/*
  Purge sequencer: steps progress from 1 to 100 percent, one step per
  STEP_MS milliseconds, and reports success or failure at the end.
  Assumes the millisecond tick and the fault input are on the core clock.
*/
`timescale 1ns/1ps
`default_nettype none
module purge_seq #(
  parameter int STEP_MS = purge_pkg::STEP_MS
) (
  input  wire logic core_clk_i,
  input  wire logic rstn_i,
  input  wire logic fault_i,
  purge_if.seq      pif
);

  typedef struct packed {
    logic       busy;
    logic       bad;
    logic       done;
    logic       ok;
    logic [6:0] pct;
    logic [11:0] ms;
  } seq_s;

  localparam logic [11:0] STEP_LAST = 12'(STEP_MS - 1);

  seq_s q, d;

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  // A spoil or a heater fault at any point taints the whole cycle.
  always_comb begin
    d      = q;
    d.done = 1'b0;
    if (!q.busy) begin
      if (pif.start) begin
        d.busy = 1'b1;
        d.bad  = 1'b0;
        d.pct  = purge_pkg::PCT_FIRST;
        d.ms   = '0;
      end
    end else begin
      if (pif.spoil || fault_i) begin
        d.bad = 1'b1;                                        // R08
      end
      if (pif.tick) begin
        if (q.ms == STEP_LAST) begin
          d.ms = '0;
          if (q.pct == purge_pkg::PCT_MAX) begin
            d.busy = 1'b0;
            d.done = 1'b1;
            d.ok   = !d.bad;                                 // R06
          end else begin
            d.pct = q.pct + 7'h01;                           // R05
          end
        end else begin
          d.ms = q.ms + 12'h001;
        end
      end
    end
  end

  // Registered state.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign pif.busy = q.busy;
  assign pif.done = q.done;
  assign pif.ok   = q.ok;
  assign pif.pct  = q.pct;

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  a_pct_in_range: assert property ( // R05
    q.busy |-> (q.pct >= purge_pkg::PCT_FIRST && q.pct <= purge_pkg::PCT_MAX))
    else $error("Purge progress out of range.");
  a_done_after_max: assert property ( // R06
    q.done |-> ($past(q.pct) == purge_pkg::PCT_MAX && !q.busy))
    else $error("Purge ended before reaching full progress.");

endmodule
`default_nettype wire

// ==== hw/purge_ctrl_top.sv ====
/*
  Purge control and analog output mode block. Holds the purge trigger and
  progress register, the per-channel mode and error level registers, the
  start-up mode strap and the start-up purge.
  Assumes a register port driven by the fieldbus frame decoder on the core
  clock, and a pull-down on the strap pin so that a floating pin reads low.
*/
// Contract
// (R01) Strap sampled after reset release; floating pin gives digital mode.
// (R02) Start-up purge runs only in analog mode, never in digital mode.
// (R03) Host starts a manual purge by writing one, once per cycle.
// (R04) Host only reads the trigger register until the purge finishes.
// (R05) During a manual purge the register reads progress from 1 to 100.
// (R06) At full progress the register becomes 0 on success, -1 on failure.
// (R07) A new start is accepted only after the final value was read.
// (R08) Any write during a purge makes that purge fail; the code fails only a manual purge, and only on a trigger register write.
// (R09) Each channel has a mode register; off drives a zero level.
// (R10) Start-up purge ends within five minutes; outputs show error meanwhile.
// (R11) Error level holds while scaling or sensor fault persists.
// (R12) Channel in error drives its configurable error level, default 3.6 mA.
// (R13) Trigger register is a signed 16-bit value.
`timescale 1ns/1ps
`default_nettype none
module purge_ctrl_top #(
  parameter int MS_CYCLES = purge_pkg::MS_CYCLES,
  parameter int STEP_MS   = purge_pkg::STEP_MS
) (
  input  wire logic        core_clk_i,
  input  wire logic        rstn_i,
  input  wire logic        mode_strap_i,
  input  wire logic [15:0] reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [15:0] reg_wdata_i,
  output logic      [15:0] reg_rdata_o,
  output logic             reg_ack_o,
  output logic             reg_err_o,
  input  wire logic        purge_fault_i,
  input  wire logic        meas_fault_i,
  input  wire logic        scale_err_i,
  input  wire logic [15:0] ch1_meas_i,
  input  wire logic [15:0] ch2_meas_i,
  output logic      [15:0] ch1_level_o,
  output logic      [15:0] ch2_level_o,
  output logic             analog_mode_o,
  output logic             purge_heat_o
);

  typedef struct packed {
    logic [2:0]       sync;
    purge_pkg::boot_e boot;
    logic [2:0]       settle;
    logic             analog;
    logic [17:0]      pre;
    logic             tick;
    logic [18:0]      boot_ms;
    logic             manual;
    logic             unread;
    logic             spoiled;
    logic [15:0]      trig;
    logic [15:0]      mode1;
    logic [15:0]      mode2;
    logic [15:0]      err1;
    logic [15:0]      err2;
    logic [15:0]      rdata;
    logic             ack;
    logic             err;
    logic [15:0]      lvl1;
    logic [15:0]      lvl2;
  } top_s;

  localparam logic [17:0] PRE_LAST = 18'(MS_CYCLES - 1);
  localparam logic [18:0] BOOT_MAX = 19'(purge_pkg::BOOT_LIMIT_MS);

  top_s q, d;
  purge_if pif ();

  purge_seq #(.STEP_MS(STEP_MS)) u_seq (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .fault_i    (purge_fault_i),
    .pif        (pif)
  );

  // Picks the level of one channel: zero when off, error level while in error.
  function automatic logic [15:0] level_of(input logic        off,
                                           input logic        in_err,
                                           input logic [15:0] mode,
                                           input logic [15:0] err_lvl,
                                           input logic [15:0] meas);
    if (off || mode == purge_pkg::MODE_OFF) begin
      level_of = purge_pkg::LEVEL_ZERO;
    end else if (in_err) begin
      level_of = err_lvl;
    end else begin
      level_of = meas;
    end
  endfunction

  // ==========================================================================
  // Next state
  // ==========================================================================
  // The trigger register mixes host writes with hardware progress, so every
  // trigger write during a manual purge spoils it rather than being silently dropped.
  always_comb begin
    logic hit;
    logic out_off;
    logic in_err;
    hit       = 1'b0;
    out_off   = !q.analog || q.boot == purge_pkg::BOOT_SETTLE;
    in_err    = pif.busy || meas_fault_i || scale_err_i;     // R10 R11
    d         = q;
    d.ack     = reg_wr_i || reg_rd_i;
    d.err     = 1'b0;
    d.sync    = {q.sync[1:0], mode_strap_i};
    pif.start = 1'b0;
    pif.spoil = 1'b0;

    // Millisecond prescaler.
    d.tick = 1'b0;
    if (q.pre == PRE_LAST) begin
      d.pre  = '0;
      d.tick = 1'b1;
    end else begin
      d.pre = q.pre + 18'h00001;
    end

    // Start-up: wait for the strap synchroniser, then latch the mode.
    case (q.boot)
      purge_pkg::BOOT_SETTLE: begin
        d.settle = q.settle + 3'h1;
        if (q.settle == purge_pkg::SETTLE_LAST && q.sync[2] == q.sync[1]) begin
          d.analog = q.sync[2];                                // R01
          if (q.sync[2]) begin
            d.boot    = purge_pkg::BOOT_PURGE;                 // R02
            pif.start = 1'b1;
          end else begin
            d.boot = purge_pkg::BOOT_RUN;                      // R02
          end
        end
      end
      purge_pkg::BOOT_PURGE: begin
        if (q.tick && q.boot_ms != BOOT_MAX) begin
          d.boot_ms = q.boot_ms + 19'h00001;
        end
        if (pif.done) begin
          d.boot = purge_pkg::BOOT_RUN;                        // R10
        end
      end
      purge_pkg::BOOT_RUN: begin
        d.boot = purge_pkg::BOOT_RUN;
      end
      default: begin
        d.boot = purge_pkg::BOOT_SETTLE;
      end
    endcase

    // Register writes.
    if (reg_wr_i) begin
      hit = 1'b1;
      case (reg_addr_i)
        purge_pkg::ADDR_TRIG: begin
          if (q.manual) begin
            d.spoiled = 1'b1;                                  // R08
            pif.spoil = 1'b1;                                  // R08
          end else if (reg_wdata_i == purge_pkg::TRIG_START && !q.unread &&
                       !pif.busy && q.boot == purge_pkg::BOOT_RUN) begin
            pif.start = 1'b1;                                  // R03 R07
            d.manual  = 1'b1;
            d.spoiled = 1'b0;
            d.trig    = {9'h000, purge_pkg::PCT_FIRST};
          end
        end
        purge_pkg::ADDR_CH1_MODE: d.mode1 = reg_wdata_i;       // R09
        purge_pkg::ADDR_CH2_MODE: d.mode2 = reg_wdata_i;       // R09
        purge_pkg::ADDR_CH1_ERR:  d.err1  = reg_wdata_i;       // R12
        purge_pkg::ADDR_CH2_ERR:  d.err2  = reg_wdata_i;       // R12
        default:                  hit     = 1'b0;
      endcase
      d.err = !hit;
    end

    // Register reads; a read of a final value re-arms the trigger.
    if (reg_rd_i) begin
      case (reg_addr_i)
        purge_pkg::ADDR_TRIG: begin
          d.rdata = q.trig;                                    // R13
          if (!q.manual) begin
            d.unread = 1'b0;                                   // R07
          end
        end
        purge_pkg::ADDR_CH1_MODE: d.rdata = q.mode1;
        purge_pkg::ADDR_CH2_MODE: d.rdata = q.mode2;
        purge_pkg::ADDR_CH1_ERR:  d.rdata = q.err1;
        purge_pkg::ADDR_CH2_ERR:  d.rdata = q.err2;
        default: begin
          d.rdata = '0;
          d.err   = 1'b1;
        end
      endcase
    end

    // Manual purge progress and final value; completion wins over a read.
    if (q.manual) begin
      d.trig = {9'h000, pif.pct};                              // R05
      if (pif.done) begin
        d.manual = 1'b0;
        d.unread = 1'b1;                                       // R07
        d.trig   = pif.ok ? purge_pkg::TRIG_OK : purge_pkg::TRIG_FAIL; // R06
      end
    end

    // Analog levels: in analog mode with the channel on, error level during any purge or persisting fault.
    d.lvl1  = level_of(out_off, in_err, q.mode1, q.err1, ch1_meas_i); // R09 R12
    d.lvl2  = level_of(out_off, in_err, q.mode2, q.err2, ch2_meas_i); // R09 R12
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q       <= '0;
      q.boot  <= purge_pkg::BOOT_SETTLE;
      q.trig  <= purge_pkg::TRIG_RST;
      q.mode1 <= purge_pkg::MODE_RST;
      q.mode2 <= purge_pkg::MODE_RST;
      q.err1  <= purge_pkg::ERR_LEVEL_RST;
      q.err2  <= purge_pkg::ERR_LEVEL_RST;
    end else begin
      q <= d;
    end
  end

  assign pif.tick      = q.tick;
  assign reg_rdata_o   = q.rdata;
  assign reg_ack_o     = q.ack;
  assign reg_err_o     = q.err;
  assign ch1_level_o   = q.lvl1;
  assign ch2_level_o   = q.lvl2;
  assign analog_mode_o = q.analog;
  assign purge_heat_o  = pif.busy;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  a_strap_mode_latch: assert property ( // R01
    ($past(q.boot) == purge_pkg::BOOT_SETTLE && q.boot != purge_pkg::BOOT_SETTLE) |->
    (q.analog == $past(q.sync[2])))
    else $error("Mode not taken from the settled strap.");
  a_digital_no_purge: assert property ( // R02
    (q.boot == purge_pkg::BOOT_PURGE) |->
    (q.analog && (pif.busy || $past(pif.start) || pif.done)))
    else $error("Start-up purge outside analog mode.");
  a_boot_purge_window: assert property (q.boot_ms < BOOT_MAX) // R10
    else $error("Start-up purge exceeded its time window.");
  a_final_value_code: assert property ( // R06
    $fell(q.manual) |-> (q.trig == purge_pkg::TRIG_OK || q.trig == purge_pkg::TRIG_FAIL))
    else $error("Purge ended without a final code.");
  a_spoiled_purge_fails: assert property ( // R08
    (q.manual && q.spoiled && pif.done) |=> (q.trig == purge_pkg::TRIG_FAIL))
    else $error("Spoiled purge reported success.");
  a_restart_after_read: assert property ( // R07
    (pif.start && q.boot == purge_pkg::BOOT_RUN) |-> (!q.unread && !q.manual))
    else $error("Purge restarted before the final value was read.");
  a_off_channel_zero: assert property ( // R09
    ($past(q.mode1) == purge_pkg::MODE_OFF) |-> (ch1_level_o == purge_pkg::LEVEL_ZERO))
    else $error("Channel set off drives a level.");
  a_error_level_out: assert property ( // R11 R12
    $past(q.analog && q.boot == purge_pkg::BOOT_RUN && q.mode2 != purge_pkg::MODE_OFF &&
          (meas_fault_i || scale_err_i)) |-> (ch2_level_o == $past(q.err2)))
    else $error("Channel in error not at its error level.");

endmodule
`default_nettype wire

// ==== verification/host_model.sv ====
/*
  Register bus host model: issues one-cycle read and write strobes on the
  purge block's register port and collects the acknowledge.
  Assumes the device answers one cycle after the taking edge.
*/
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic        core_clk_i,
  output logic      [15:0] reg_addr_o,
  output logic             reg_wr_o,
  output logic             reg_rd_o,
  output logic      [15:0] reg_wdata_o,
  input  wire logic [15:0] reg_rdata_i,
  input  wire logic        reg_ack_i,
  input  wire logic        reg_err_i
);
  // ==========================================================================
  // Idle state
  // ==========================================================================
  // Bus idles with no strobe at time zero.
  initial begin
    reg_addr_o  = 16'h0000;
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    reg_wdata_o = 16'h0000;
  end

  // ==========================================================================
  // One access
  // ==========================================================================
  // Address and data are inverted once the strobe drops, so a device that
  // samples them outside the strobe sees garbage rather than a lucky value.
  task automatic access(input logic wr, input logic [15:0] addr, input logic [15:0] data,
                        output logic [15:0] rdata, output logic err);
    int n;
    @(posedge core_clk_i);
    reg_addr_o  <= addr;
    reg_wdata_o <= data;
    reg_wr_o    <= wr;
    reg_rd_o    <= !wr;
    @(posedge core_clk_i);
    reg_wr_o    <= 1'b0;
    reg_rd_o    <= 1'b0;
    reg_addr_o  <= ~addr;
    reg_wdata_o <= ~data;
    n = 0;
    @(negedge core_clk_i);
    while (reg_ack_i !== 1'b1 && n < 4) begin
      @(negedge core_clk_i);
      n++;
    end
    rdata = reg_rdata_i;
    err   = (reg_ack_i === 1'b1) ? reg_err_i : 1'bx;
  endtask
endmodule
`default_nettype wire

// ==== verification/testbench.sv ====
/*
  Self-checking bench for the purge control block: mode strap, start-up
  purge, manual purge handshake and analog output levels.
  Assumes shortened millisecond and step counts set at the instance.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int MS   = 4;
  localparam int STEP = 2;
  logic        core_clk_i    = 1'b0;
  logic        rstn_i        = 1'b0;
  logic        mode_strap_i  = 1'b0;
  logic        purge_fault_i = 1'b0;
  logic        meas_fault_i  = 1'b0;
  logic        scale_err_i   = 1'b0;
  logic [15:0] ch1_meas_i    = 16'h1000;
  logic [15:0] ch2_meas_i    = 16'h2000;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, ch1_level, ch2_level;
  logic        reg_wr, reg_rd, reg_ack, reg_err, analog_mode, purge_heat;
  int          num_errors = 0;
  int          n_compared = 0;
  int          seed       = 32'he5efdca8;

  // Free-running 200 MHz core clock.
  always #2.5 core_clk_i = ~core_clk_i;

  host_model host_model_inst (.core_clk_i(core_clk_i), .reg_addr_o(reg_addr),
    .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_wdata_o(reg_wdata),
    .reg_rdata_i(reg_rdata), .reg_ack_i(reg_ack), .reg_err_i(reg_err));

  purge_ctrl_top #(.MS_CYCLES(MS), .STEP_MS(STEP)) purge_ctrl_top_inst (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .mode_strap_i(mode_strap_i),
    .reg_addr_i(reg_addr), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_wdata_i(reg_wdata),
    .reg_rdata_o(reg_rdata), .reg_ack_o(reg_ack), .reg_err_o(reg_err),
    .purge_fault_i(purge_fault_i), .meas_fault_i(meas_fault_i), .scale_err_i(scale_err_i),
    .ch1_meas_i(ch1_meas_i), .ch2_meas_i(ch2_meas_i), .ch1_level_o(ch1_level),
    .ch2_level_o(ch2_level), .analog_mode_o(analog_mode), .purge_heat_o(purge_heat));

  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wrap_up;
    $display("errors %0d of %0d comparisons", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    logic [15:0] v;
    logic        e;
    host_model_inst.access(1'b1, a, d, v, e);
    check("write_err", 16'h0000, 16'(e));
  endtask

  task automatic rd(input logic [15:0] a, output logic [15:0] v);
    logic e;
    host_model_inst.access(1'b0, a, 16'h0000, v, e);
    check("read_err", 16'h0000, 16'(e));
  endtask

  // Strap is set while reset is low, so it is settled before sampling.
  task automatic do_reset(input logic strap);
    @(posedge core_clk_i);
    rstn_i       <= 1'b0;
    mode_strap_i <= strap;
    repeat (20) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    repeat (10) @(negedge core_clk_i);
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    while (purge_heat !== 1'b0 && n < 2000) begin
      @(negedge core_clk_i);
      n++;
    end
    check("purge_done", 16'h0000, 16'(purge_heat));
  endtask

  function automatic logic [15:0] exp_final(input int how);
    return (how == 0) ? purge_pkg::TRIG_OK : purge_pkg::TRIG_FAIL;
  endfunction

  function automatic logic [15:0] exp_level(input logic [15:0] mode, input logic [15:0] err,
                                            input logic [15:0] meas, input logic bad);
    if (mode == purge_pkg::MODE_OFF) return purge_pkg::LEVEL_ZERO;
    return bad ? err : meas;
  endfunction

  // ==========================================================================
  // Manual purge: how 0 clean, 1 spoiled by a write, 2 spoiled by a fault
  // ==========================================================================
  // Polling stops at full progress so the final value stays unread while a
  // premature restart is tried; reading it early would re-arm the trigger.
  task automatic run_purge(input int how);
    logic [15:0] v, peak;
    int          i;
    peak = 16'h0001;
    v    = 16'h0000;
    wr(purge_pkg::ADDR_TRIG, purge_pkg::TRIG_START);
    check("purge_start", 16'h0001, 16'(purge_heat));
    for (i = 0; i < 1000 && v !== 16'(purge_pkg::PCT_MAX); i++) begin
      rd(purge_pkg::ADDR_TRIG, v);
      if (v < 16'h0001 || v > 16'h0064 || v < peak) check("progress", peak, v);
      peak = v;
      if (i == 2 && how == 1) wr(purge_pkg::ADDR_TRIG, 16'($random(seed)));
      if (i == 2 && how == 2) begin
        @(posedge core_clk_i);
        purge_fault_i <= 1'b1;
        @(posedge core_clk_i);
        purge_fault_i <= 1'b0;
      end
    end
    check("progress_peak", 16'h0064, v);
    wait_idle();
    wr(purge_pkg::ADDR_TRIG, purge_pkg::TRIG_START);
    repeat (2) @(negedge core_clk_i);
    check("early_restart", 16'h0000, 16'(purge_heat));
    rd(purge_pkg::ADDR_TRIG, v);
    check("final_code", exp_final(how), v);
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    logic [15:0] v, m1, e2;
    logic        e, b;
    logic [15:0] addrs [5] = '{purge_pkg::ADDR_TRIG, purge_pkg::ADDR_CH1_MODE,
      purge_pkg::ADDR_CH2_MODE, purge_pkg::ADDR_CH1_ERR, purge_pkg::ADDR_CH2_ERR};
    logic [15:0] rsts  [5] = '{purge_pkg::TRIG_RST, purge_pkg::MODE_RST, purge_pkg::MODE_RST,
      purge_pkg::ERR_LEVEL_RST, purge_pkg::ERR_LEVEL_RST};
    do_reset(1'b0);
    check("digital_mode", 16'h0000, 16'(analog_mode));
    check("no_boot_purge", 16'h0000, 16'(purge_heat));
    check("digital_level", 16'h0000, ch1_level);
    for (int k = 0; k < 5; k++) begin
      rd(addrs[k], v);
      check("reset_value", rsts[k], v);
    end
    host_model_inst.access(1'b0, 16'h0600, 16'h0000, v, e);
    check("unmapped_err", 16'h0001, 16'(e));
    host_model_inst.access(1'b1, 16'h0600, 16'h1234, v, e);
    check("unmapped_wr_err", 16'h0001, 16'(e));
    for (int how = 0; how < 3; how++) run_purge(how);
    check("digital_level2", 16'h0000, ch2_level);
    do_reset(1'b1);
    check("analog_mode", 16'h0001, 16'(analog_mode));
    check("boot_purge", 16'h0001, 16'(purge_heat));
    check("boot_level", purge_pkg::ERR_LEVEL_RST, ch1_level);
    wait_idle();
    // Random levels, error levels, faults and modes, with mode off forced on even passes.
    for (int k = 0; k < 6; k++) begin
      m1 = (k % 2 == 0) ? purge_pkg::MODE_OFF : 16'($random(seed)) | 16'h0001;
      e2 = 16'($random(seed)) & 16'h3fff;
      wr(purge_pkg::ADDR_CH1_MODE, m1);
      wr(purge_pkg::ADDR_CH2_ERR, e2);
      @(posedge core_clk_i);
      ch1_meas_i   <= 16'($random(seed)) & 16'h3fff;
      ch2_meas_i   <= 16'($random(seed)) & 16'h3fff;
      meas_fault_i <= 1'($random(seed));
      scale_err_i  <= (k == 3);
      repeat (3) @(negedge core_clk_i);
      b = meas_fault_i | scale_err_i;
      v = exp_level(m1, purge_pkg::ERR_LEVEL_RST, ch1_meas_i, b);
      check("ch1_level", v, ch1_level);
      check("ch2_level", exp_level(16'h0001, e2, ch2_meas_i, b), ch2_level);
    end
    wrap_up();
  end

  // Whole run is about 3400 cycles; this limit is over five times that.
  initial begin
    #100000;
    num_errors++;
    wrap_up();
  end
endmodule
`default_nettype wire
